// >>> logic/sccs_pkg.sv
// package of register offsets, codes and timing constants for the sample clock select block
package sccs_pkg;
	// register offsets (indexes; byte address is four times the index)
	localparam logic [15:0] OFS_BOARD_COMMAND     = 16'h0000;
	localparam logic [15:0] OFS_EXT_CLOCK_DIVIDER = 16'h4E48;
	localparam logic [15:0] OFS_EXT_CLOCK_ENABLE  = 16'h4E84;
	localparam logic [15:0] OFS_CLOCK_TERMINATION = 16'h4E98;
	localparam logic [15:0] OFS_EXT_CLOCK_BAND    = 16'h4EA2;
	localparam logic [15:0] OFS_REFERENCE_SELECT  = 16'h4EAC;
	localparam logic [15:0] OFS_TRIGGER_MODE      = 16'h9C40;
	localparam logic [15:0] OFS_SAMPLE_RATE       = 16'h4E20;
	localparam logic [15:0] OFS_STATUS            = 16'h4F00;
	// codes
	localparam logic [31:0] REF_INTERNAL          = 32'h0000_0000;
	localparam logic [31:0] BACKPLANE_REF_CODE    = 32'hFFFF_FFFF;
	localparam logic [31:0] BAND_SINGLE           = 32'h0000_0002;
	localparam logic [31:0] BAND_SMALL            = 32'h0000_0004;
	localparam logic [31:0] BAND_MEDIUM           = 32'h0000_0008;
	localparam logic [31:0] BAND_LARGE            = 32'h0000_0010;
	localparam logic [31:0] BAND_EXTRA_LARGE      = 32'h0000_0020;
	localparam logic [31:0] FREE_RUN_TRIGGER      = 32'h0000_0000;
	localparam logic [31:0] CMD_START             = 32'h0000_0004;
	localparam logic [31:0] CMD_STOP              = 32'h0000_0008;
	localparam logic [31:0] FORCED_TRIGGER_CMD    = 32'h0000_0010;
	// reset values
	localparam logic [31:0] RST_DIVIDER           = 32'h0000_0001;
	localparam logic [31:0] RST_BAND              = 32'h0000_0002;
	localparam logic [31:0] RST_TRIGGER_MODE      = 32'h0000_0000;
	// timing: board setup delay before free run acquisition
	localparam int          SETUP_TIME_NS         = 1000;
	localparam int          CLK_PERIOD_NS         = 5;
	localparam int          SETUP_CYCLES          = (SETUP_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// status bits
	localparam int          ST_ARMED_BIT          = 0;
	localparam int          ST_RUN_BIT            = 1;
	localparam int          ST_EXT_BIT            = 2;
	localparam int          ST_BACKPLANE_BIT      = 3;
	localparam int          ST_EXT_REF_BIT        = 4;
	// pll source codes driven out
	localparam logic [1:0]  PLL_SRC_INTERNAL      = 2'h0;
	localparam logic [1:0]  PLL_SRC_EXTERNAL      = 2'h1;
	localparam logic [1:0]  PLL_SRC_BACKPLANE     = 2'h2;
endpackage

// >>> logic/sccs_clk_divider.sv
// divider that turns the synchronised external clock edges into sample enables
module sccs_clk_divider #(
	parameter int W = 12
) (
	input  wire logic         clk_sys_i,  // system clock
	input  wire logic         sys_rst_i,  // synchronous reset
	input  wire logic         edge_i,     // one pulse per external clock edge
	input  wire logic [W-1:0] ratio_i,    // division ratio, at least 1
	output logic              tick_o      // one-cycle sample enable
);
	logic [W-1:0] cnt_ff;
	wire          last_w = (cnt_ff >= ratio_i - W'(1));

	// count edges; emit a tick on the last of each group
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			cnt_ff <= '0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= edge_i && last_w;
			if (edge_i)
				cnt_ff <= last_w ? '0 : cnt_ff + W'(1);
		end
	end
endmodule

// >>> logic/sccs_top.sv
// sample clock source select: reference routing, external clock, band, divider, trigger
// How it works
// - reference zero internal, positive selects external
// - pll settings follow reference and sample rate
// - termination only while connector is an input
// - external enable samples on external clock
// - band accepts codes 2,4,8,16,32
// - divided external clock forms sample clock
// - divider accepts only listed seventeen values
// - minus one routes backplane reference to pll
// - free run trigger starts after setup time
// - forced trigger only while armed and waiting
// - received trigger never repeated onward
module sccs_top #(
	parameter int DIV_W = 12
) (
	input  wire logic        clk_sys_i,        // 200 MHz system clock
	input  wire logic        sys_rst_i,        // synchronous reset, active high
	input  wire logic        reg_wr_i,         // register write strobe
	input  wire logic        reg_rd_i,         // register read strobe
	input  wire logic [15:0] reg_addr_i,       // register index
	input  wire logic [31:0] reg_wdata_i,      // write data
	output logic      [31:0] reg_rdata_o,      // read data, valid cycle after read
	input  wire logic        ext_clk_pin_i,    // external clock connector level
	input  wire logic        ext_trig_pin_i,   // external trigger connector level
	output logic             term_50ohm_o,     // 50 ohm load on clock connector
	output logic       [1:0] pll_src_o,        // pll reference source
	output logic      [31:0] pll_ref_hz_o,     // reference frequency for pll setup
	output logic      [31:0] pll_rate_hz_o,    // requested sample rate for pll setup
	output logic             pll_load_o,       // pulse: reference or sample rate written
	output logic             use_ext_clk_o,    // sampling on external clock
	output logic             sample_tick_o,    // sample enable from divided external clock
	output logic             trig_o,           // one-cycle trigger event
	output logic             trig_pin_o,       // trigger connector output value
	output logic             trig_pin_oe_n_o,  // trigger connector enable, low drives
	output logic             acq_run_o         // acquisition running
);
	// configuration registers
	logic [31:0] ref_sel_ff, rate_ff, div_ff, band_ff, trig_mode_ff;
	logic        ext_en_ff, term_ff;
	// synchronisers for connector inputs
	logic [1:0]  clk_sync_ff, trig_sync_ff;
	logic        clk_prev_ff, trig_prev_ff;
	// board sequence
	typedef enum logic [3:0] {
		SCCS_IDLE  = 4'b0001,
		SCCS_SETUP = 4'b0010,
		SCCS_ARMED = 4'b0100,
		SCCS_RUN   = 4'b1000
	} sccs_state_e;
	sccs_state_e state_ff, nxt_state;
	logic [15:0] setup_cnt_ff;
	logic        div_tick;

	// address decode
	wire wr_cmd  = reg_wr_i && reg_addr_i == sccs_pkg::OFS_BOARD_COMMAND;
	wire wr_div  = reg_wr_i && reg_addr_i == sccs_pkg::OFS_EXT_CLOCK_DIVIDER;
	wire wr_ext  = reg_wr_i && reg_addr_i == sccs_pkg::OFS_EXT_CLOCK_ENABLE;
	wire wr_term = reg_wr_i && reg_addr_i == sccs_pkg::OFS_CLOCK_TERMINATION;
	wire wr_band = reg_wr_i && reg_addr_i == sccs_pkg::OFS_EXT_CLOCK_BAND;
	wire wr_ref  = reg_wr_i && reg_addr_i == sccs_pkg::OFS_REFERENCE_SELECT;
	wire wr_rate = reg_wr_i && reg_addr_i == sccs_pkg::OFS_SAMPLE_RATE;
	wire wr_trig = reg_wr_i && reg_addr_i == sccs_pkg::OFS_TRIGGER_MODE;

	// legal band codes: single one-hot value among the five bands
	wire band_ok = reg_wdata_i == sccs_pkg::BAND_SINGLE
		|| reg_wdata_i == sccs_pkg::BAND_SMALL
		|| reg_wdata_i == sccs_pkg::BAND_MEDIUM
		|| reg_wdata_i == sccs_pkg::BAND_LARGE
		|| reg_wdata_i == sccs_pkg::BAND_EXTRA_LARGE;
	// legal divider values; anything else keeps the old setting
	logic div_ok;
	always_comb begin
		unique case (reg_wdata_i)
			32'h1, 32'h2, 32'h4, 32'h8, 32'hA, 32'h10, 32'h14, 32'h28,
			32'h32, 32'h50, 32'h64, 32'hC8, 32'h190, 32'h1F4, 32'h320,
			32'h3E8, 32'h7D0: div_ok = 1'b1;
			default: div_ok = 1'b0;
		endcase
	end

	// reference decode: zero internal, minus one backplane, positive external
	wire         ref_backplane = ref_sel_ff == sccs_pkg::BACKPLANE_REF_CODE;
	wire         ref_external  = !ref_sel_ff[31] && ref_sel_ff != '0;
	wire   [1:0] nxt_pll_src   = ref_backplane ? sccs_pkg::PLL_SRC_BACKPLANE :
		ref_external ? sccs_pkg::PLL_SRC_EXTERNAL : sccs_pkg::PLL_SRC_INTERNAL;
	wire  [31:0] nxt_pll_ref   = ref_backplane ? 32'h0098_9680 :   // 10 MHz
		ref_external ? ref_sel_ff : 32'h0262_5A00;                 // 40 MHz internal
	// connector is an input when clocking or referencing externally
	wire         conn_input    = ext_en_ff || ref_external;

	// configuration writes; illegal band or divider writes are dropped
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ref_sel_ff   <= sccs_pkg::REF_INTERNAL;
			rate_ff      <= '0;
			div_ff       <= sccs_pkg::RST_DIVIDER;
			band_ff      <= sccs_pkg::RST_BAND;
			trig_mode_ff <= sccs_pkg::RST_TRIGGER_MODE;
			ext_en_ff    <= 1'b0;
			term_ff      <= 1'b0;
		end else begin
			if (wr_ref)
				ref_sel_ff <= reg_wdata_i;
			if (wr_rate)
				rate_ff <= reg_wdata_i;
			if (wr_div && div_ok)
				div_ff <= reg_wdata_i;
			if (wr_band && band_ok)
				band_ff <= reg_wdata_i;
			if (wr_trig)
				trig_mode_ff <= reg_wdata_i;
			if (wr_ext)
				ext_en_ff <= reg_wdata_i[0];
			if (wr_term)
				term_ff <= reg_wdata_i[0];
		end
	end

	// pll setup outputs; a load pulse follows each reference or rate write, one cycle before the new value appears
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			pll_src_o     <= sccs_pkg::PLL_SRC_INTERNAL;
			pll_ref_hz_o  <= '0;
			pll_rate_hz_o <= '0;
			pll_load_o    <= 1'b0;
			term_50ohm_o  <= 1'b0;
			use_ext_clk_o <= 1'b0;
		end else begin
			pll_src_o     <= nxt_pll_src;
			pll_ref_hz_o  <= nxt_pll_ref;
			pll_rate_hz_o <= rate_ff;
			pll_load_o    <= wr_ref || wr_rate;
			term_50ohm_o  <= term_ff && conn_input;
			use_ext_clk_o <= ext_en_ff;
		end
	end

	// two-stage synchronisers; edge detect only reads the second stage
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			clk_sync_ff  <= '0;
			trig_sync_ff <= '0;
			clk_prev_ff  <= 1'b0;
			trig_prev_ff <= 1'b0;
		end else begin
			clk_sync_ff  <= {clk_sync_ff[0], ext_clk_pin_i};
			trig_sync_ff <= {trig_sync_ff[0], ext_trig_pin_i};
			clk_prev_ff  <= clk_sync_ff[1];
			trig_prev_ff <= trig_sync_ff[1];
		end
	end
	wire clk_rise = clk_sync_ff[1] && !clk_prev_ff;
	wire trig_rise = trig_sync_ff[1] && !trig_prev_ff;

	// external clock is divided; only sampled when external clocking is enabled
	// limitation: the oversampling clock caps the usable external rate well below 100 MHz
	sccs_clk_divider #(
		.W (DIV_W)
	) u_div (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.edge_i    (clk_rise && ext_en_ff),
		.ratio_i   (div_ff[DIV_W-1:0]),
		.tick_o    (div_tick)
	);

	// board sequence: start, setup delay, armed until trigger, run until stop
	wire cmd_start = wr_cmd && reg_wdata_i == sccs_pkg::CMD_START;
	wire cmd_stop  = wr_cmd && reg_wdata_i == sccs_pkg::CMD_STOP;
	wire cmd_force = wr_cmd && reg_wdata_i == sccs_pkg::FORCED_TRIGGER_CMD;
	wire free_run  = trig_mode_ff == sccs_pkg::FREE_RUN_TRIGGER;
	wire setup_done = setup_cnt_ff == 16'(sccs_pkg::SETUP_CYCLES - 1);
	wire armed     = state_ff == SCCS_ARMED;
	// forced trigger only counts while armed; external edges only in external mode
	wire trig_hit  = armed && (cmd_force || (!free_run && trig_rise));

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			SCCS_IDLE:  if (cmd_start) nxt_state = SCCS_SETUP;
			SCCS_SETUP: if (cmd_stop) nxt_state = SCCS_IDLE;
				else if (setup_done)
					nxt_state = free_run ? SCCS_RUN : SCCS_ARMED;
			SCCS_ARMED: if (cmd_stop) nxt_state = SCCS_IDLE;
				else if (trig_hit) nxt_state = SCCS_RUN;
			SCCS_RUN:   if (cmd_stop) nxt_state = SCCS_IDLE;
			default:    nxt_state = SCCS_IDLE;
		endcase
	end

	// state register and setup delay counter
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state_ff     <= SCCS_IDLE;
			setup_cnt_ff <= '0;
		end else begin
			state_ff     <= nxt_state;
			setup_cnt_ff <= (state_ff == SCCS_SETUP) ? setup_cnt_ff + 16'h0001 : 16'h0000;
		end
	end

	// trigger outputs; the connector is never driven with a received edge
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			trig_o          <= 1'b0;
			trig_pin_o      <= 1'b0;
			trig_pin_oe_n_o <= 1'b1;
			acq_run_o       <= 1'b0;
			sample_tick_o   <= 1'b0;
		end else begin
			trig_o          <= trig_hit
				|| (state_ff == SCCS_SETUP && setup_done && free_run && !cmd_stop);
			trig_pin_o      <= 1'b0;
			trig_pin_oe_n_o <= 1'b1;
			acq_run_o       <= nxt_state == SCCS_RUN;
			sample_tick_o   <= div_tick && nxt_state == SCCS_RUN;
		end
	end

	// read back; unmapped indexes read zero, status shows the board state
	wire [31:0] status_w = {27'h0, ref_external, ref_backplane, ext_en_ff,
		state_ff == SCCS_RUN, armed};
	wire [31:0] rd_mux =
		reg_addr_i == sccs_pkg::OFS_EXT_CLOCK_DIVIDER ? div_ff :
		reg_addr_i == sccs_pkg::OFS_EXT_CLOCK_ENABLE  ? {31'h0, ext_en_ff} :
		reg_addr_i == sccs_pkg::OFS_CLOCK_TERMINATION ? {31'h0, term_ff} :
		reg_addr_i == sccs_pkg::OFS_EXT_CLOCK_BAND    ? band_ff :
		reg_addr_i == sccs_pkg::OFS_REFERENCE_SELECT  ? ref_sel_ff :
		reg_addr_i == sccs_pkg::OFS_SAMPLE_RATE       ? rate_ff :
		reg_addr_i == sccs_pkg::OFS_TRIGGER_MODE      ? trig_mode_ff :
		reg_addr_i == sccs_pkg::OFS_STATUS            ? status_w : 32'h0;
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i)
			reg_rdata_o <= '0;
		else if (reg_rd_i)
			reg_rdata_o <= rd_mux;
	end

	// checks
	term_gate_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		term_50ohm_o |-> $past(term_ff && conn_input))
		else $error("termination on while connector not an input");
	band_keep_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		wr_band && !band_ok |=> $stable(band_ff))
		else $error("illegal band code changed setting");
	div_keep_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		wr_div && !div_ok |=> $stable(div_ff))
		else $error("illegal divider changed setting");
	bp_route_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		ref_backplane |=> pll_src_o == sccs_pkg::PLL_SRC_BACKPLANE)
		else $error("backplane reference not routed");
	int_route_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		ref_sel_ff == '0 |=> pll_src_o == sccs_pkg::PLL_SRC_INTERNAL)
		else $error("internal reference not selected");
	force_idle_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		cmd_force && !armed && state_ff != SCCS_SETUP |=> !trig_o)
		else $error("forced trigger outside armed state");
	sequence s_start; state_ff == SCCS_IDLE && cmd_start && free_run; endsequence
	free_run_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		s_start ##1 !cmd_stop [*8] |-> state_ff == SCCS_SETUP)
		else $error("free run started before setup time");
	trig_out_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		trig_rise |=> trig_pin_oe_n_o)
		else $error("received trigger driven onward");
	ext_sel_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		wr_ext |=> ##1 use_ext_clk_o == $past(reg_wdata_i[0], 2))
		else $error("external clock select not applied");
	// a positive reference reaches the pll with its own frequency
	ref_ext_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		ref_external |=> pll_src_o == sccs_pkg::PLL_SRC_EXTERNAL
			&& pll_ref_hz_o == $past(ref_sel_ff))
		else $error("external reference not routed");
	load_pulse_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		wr_ref || wr_rate |=> pll_load_o)
		else $error("pll load missing after setting change");
	rate_follow_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		wr_rate |=> ##1 pll_rate_hz_o == $past(reg_wdata_i, 2))
		else $error("sample rate not passed to pll setup");
	term_off_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		!conn_input |=> !term_50ohm_o)
		else $error("termination on while connector unused");
	band_take_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		wr_band && band_ok |=> band_ff == $past(reg_wdata_i))
		else $error("legal band code not stored");
	div_take_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		wr_div && div_ok |=> div_ff == $past(reg_wdata_i))
		else $error("legal divider not stored");
	tick_run_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		sample_tick_o |-> acq_run_o)
		else $error("sample enable outside acquisition");
	// armed board hit by the forced trigger command
	sequence s_force_hit;
		armed && cmd_force && !cmd_stop;
	endsequence
	force_hit_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		s_force_hit |=> trig_o && acq_run_o)
		else $error("forced trigger while armed did not start");
	// last setup cycle in free run mode
	sequence s_setup_end;
		state_ff == SCCS_SETUP && setup_done && free_run && !cmd_stop;
	endsequence
	free_go_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		s_setup_end |=> trig_o && acq_run_o)
		else $error("free run did not start after setup");
endmodule

// >>> bench/sccs_ext_source.sv
// model of the far side: external clock generator and external trigger source
module sccs_ext_source (
	input  wire logic        clk_en_i,    // run the external clock
	input  wire logic [31:0] half_ns_i,   // requested half period in ns
	input  wire logic        trig_req_i,  // rising edge asks for one trigger pulse
	output logic             ext_clk_o,   // external clock connector level
	output logic             ext_trig_o   // external trigger connector level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] half_use;

	// keep the half period inside the band the board tolerates
	assign half_use = (half_ns_i < 32'h0000_000A) ? 32'h0000_000A :
		(half_ns_i > 32'h0007_A120) ? 32'h0007_A120 : half_ns_i;

	// fixed period while running, so the clock never drifts out of its band
	initial begin
		ext_clk_o = 1'b0;
		forever begin
			if (clk_en_i) begin
				#(half_use) ext_clk_o = ~ext_clk_o;
			end else begin
				ext_clk_o = 1'b0;
				#1;
			end
		end
	end

	// one 50 ns high pulse per request, idle low between
	initial ext_trig_o = 1'b0;
	always @(posedge trig_req_i) begin
		ext_trig_o = 1'b1;
		#50 ext_trig_o = 1'b0;
	end
endmodule

// >>> bench/sccs_top_bench.sv
// self-checking bench for the sample clock source select block
module sccs_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, term, load, use_ext, tick, trig;
	logic        trig_pin, oe_n, run, ext_clk, ext_trig, src_en, trig_req, ok;
	logic        rd_d1 = 1'b0, rd_d2 = 1'b0, oe_seen = 1'b0;
	logic [1:0]  src;
	logic [15:0] reg_addr_i, lfsr = 16'h001D;
	logic [31:0] reg_wdata_i, rdata, ref_hz, rate_hz, half_ns, div_now, v;
	logic [31:0] exp_q [$];
	logic [11:0] legal_div [17] = '{12'h001, 12'h002, 12'h004, 12'h008, 12'h00A, 12'h010,
		12'h014, 12'h028, 12'h032, 12'h050, 12'h064, 12'h0C8, 12'h190, 12'h1F4, 12'h320,
		12'h3E8, 12'h7D0};
	int          n_fail = 0, comparisons = 0, n_load = 0, n_trig = 0, n_tick = 0, cnt, k;

	sccs_top #(.DIV_W(12)) dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata), .ext_clk_pin_i(ext_clk),
		.ext_trig_pin_i(ext_trig), .term_50ohm_o(term), .pll_src_o(src), .pll_ref_hz_o(ref_hz),
		.pll_rate_hz_o(rate_hz), .pll_load_o(load), .use_ext_clk_o(use_ext),
		.sample_tick_o(tick), .trig_o(trig), .trig_pin_o(trig_pin), .trig_pin_oe_n_o(oe_n),
		.acq_run_o(run));
	sccs_ext_source src_m (.clk_en_i(src_en), .half_ns_i(half_ns), .trig_req_i(trig_req),
		.ext_clk_o(ext_clk), .ext_trig_o(ext_trig));

	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// one write pulse, then let the config outputs settle (two cycles behind)
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge clk_sys_i);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge clk_sys_i);
		reg_wr_i = 1'b0;
		repeat (3) @(negedge clk_sys_i);
	endtask

	// read pulse; the expected word goes on the queue for the watcher
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		@(negedge clk_sys_i);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		exp_q.push_back(e);
		@(negedge clk_sys_i);
		reg_rd_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
	endtask

	// bounded wait for acquisition to run; running out is a mismatch
	task automatic wait_run(output int n);
		n = 0;
		while (run !== 1'b1 && n < 400) begin
			@(negedge clk_sys_i);
			n++;
		end
		// one more edge so the watcher has counted the pulses of the last one
		@(negedge clk_sys_i);
		if (n >= 400) begin
			n_fail++;
			finish_test();
		end
	endtask

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	always @(posedge clk_sys_i) begin
		rd_d1 <= reg_rd_i;
		rd_d2 <= rd_d1;
	end

	// pulses stand one cycle, so they are counted mid-cycle where they are settled
	always @(negedge clk_sys_i) begin
		if (rd_d2 && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
		if (load === 1'b1) n_load++;
		if (trig === 1'b1) n_trig++;
		if (tick === 1'b1) n_tick++;
		if (oe_n !== 1'b1 || trig_pin !== 1'b0) oe_seen = 1'b1;
	end

	initial begin
		sys_rst_i = 1'b1;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 16'h0000;
		reg_wdata_i = 32'h0000_0000;
		src_en = 1'b0;
		half_ns = 32'h0000_0028;
		trig_req = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		sys_rst_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		chk({30'h0, src}, {30'h0, sccs_pkg::PLL_SRC_INTERNAL});
		chk(ref_hz, 32'h0262_5A00);
		rd(sccs_pkg::OFS_EXT_CLOCK_DIVIDER, sccs_pkg::RST_DIVIDER);
		rd(sccs_pkg::OFS_EXT_CLOCK_BAND, sccs_pkg::RST_BAND);
		rd(sccs_pkg::OFS_TRIGGER_MODE, sccs_pkg::RST_TRIGGER_MODE);
		rd(sccs_pkg::OFS_REFERENCE_SELECT, sccs_pkg::REF_INTERNAL);
		rd(16'h1234, 32'h0000_0000);
		// every band code, then a refused code keeps the last one
		for (int i = 0; i < 5; i++) begin
			v = 32'h0000_0002 << i;
			wr(sccs_pkg::OFS_EXT_CLOCK_BAND, v);
			rd(sccs_pkg::OFS_EXT_CLOCK_BAND, v);
		end
		wr(sccs_pkg::OFS_EXT_CLOCK_BAND, 32'h0000_0003);
		rd(sccs_pkg::OFS_EXT_CLOCK_BAND, sccs_pkg::BAND_EXTRA_LARGE);
		// every divider value, then random words that are mostly refused
		foreach (legal_div[i]) begin
			wr(sccs_pkg::OFS_EXT_CLOCK_DIVIDER, {20'h0, legal_div[i]});
			rd(sccs_pkg::OFS_EXT_CLOCK_DIVIDER, {20'h0, legal_div[i]});
		end
		div_now = 32'h0000_07D0;
		repeat (8) begin
			lfsr = lfsr_next(lfsr);
			v = {16'h0, lfsr};
			foreach (legal_div[i]) if ({20'h0, legal_div[i]} == v) div_now = v;
			wr(sccs_pkg::OFS_EXT_CLOCK_DIVIDER, v);
			rd(sccs_pkg::OFS_EXT_CLOCK_DIVIDER, div_now);
		end
		// reference routing and termination
		wr(sccs_pkg::OFS_CLOCK_TERMINATION, 32'h0000_0001);
		chk({31'h0, term}, 32'h0000_0000);
		cnt = n_load;
		wr(sccs_pkg::OFS_REFERENCE_SELECT, 32'h0098_9680);
		chk({30'h0, src}, {30'h0, sccs_pkg::PLL_SRC_EXTERNAL});
		chk(ref_hz, 32'h0098_9680);
		chk({31'h0, term}, 32'h0000_0001);
		chk(n_load, cnt + 1);
		wr(sccs_pkg::OFS_REFERENCE_SELECT, sccs_pkg::BACKPLANE_REF_CODE);
		chk({30'h0, src}, {30'h0, sccs_pkg::PLL_SRC_BACKPLANE});
		chk(ref_hz, 32'h0098_9680);
		chk({31'h0, term}, 32'h0000_0000);
		wr(sccs_pkg::OFS_REFERENCE_SELECT, sccs_pkg::REF_INTERNAL);
		chk({30'h0, src}, {30'h0, sccs_pkg::PLL_SRC_INTERNAL});
		chk(ref_hz, 32'h0262_5A00);
		cnt = n_load;
		wr(sccs_pkg::OFS_SAMPLE_RATE, 32'h017D_7840);
		chk(rate_hz, 32'h017D_7840);
		chk(n_load, cnt + 1);
		wr(sccs_pkg::OFS_EXT_CLOCK_ENABLE, 32'h0000_0001);
		chk({31'h0, use_ext}, 32'h0000_0001);
		chk({31'h0, term}, 32'h0000_0001);
		wr(sccs_pkg::OFS_EXT_CLOCK_ENABLE, 32'h0000_0000);
		chk({31'h0, use_ext}, 32'h0000_0000);
		// free run: one trigger once the setup time has passed
		cnt = n_trig;
		wr(sccs_pkg::OFS_BOARD_COMMAND, sccs_pkg::CMD_START);
		wait_run(k);
		ok = (k + 4 >= sccs_pkg::SETUP_CYCLES) && (k + 4 <= sccs_pkg::SETUP_CYCLES + 8);
		chk({31'h0, ok}, 32'h0000_0001);
		chk(n_trig, cnt + 1);
		wr(sccs_pkg::OFS_BOARD_COMMAND, sccs_pkg::CMD_STOP);
		// forced trigger does nothing unless armed
		wr(sccs_pkg::OFS_TRIGGER_MODE, 32'h0000_4E20);
		cnt = n_trig;
		wr(sccs_pkg::OFS_BOARD_COMMAND, sccs_pkg::FORCED_TRIGGER_CMD);
		chk(n_trig, cnt);
		wr(sccs_pkg::OFS_BOARD_COMMAND, sccs_pkg::CMD_START);
		repeat (220) @(negedge clk_sys_i);
		chk({31'h0, run}, 32'h0000_0000);
		rd(sccs_pkg::OFS_STATUS, 32'h0000_0001 << sccs_pkg::ST_ARMED_BIT);
		wr(sccs_pkg::OFS_BOARD_COMMAND, sccs_pkg::FORCED_TRIGGER_CMD);
		chk(n_trig, cnt + 1);
		chk({31'h0, run}, 32'h0000_0001);
		rd(sccs_pkg::OFS_STATUS, 32'h0000_0001 << sccs_pkg::ST_RUN_BIT);
		// external trigger is taken but never driven back out
		wr(sccs_pkg::OFS_BOARD_COMMAND, sccs_pkg::CMD_STOP);
		wr(sccs_pkg::OFS_BOARD_COMMAND, sccs_pkg::CMD_START);
		repeat (220) @(negedge clk_sys_i);
		trig_req = 1'b1;
		repeat (20) @(negedge clk_sys_i);
		trig_req = 1'b0;
		chk(n_trig, cnt + 2);
		chk({31'h0, oe_seen}, 32'h0000_0000);
		wr(sccs_pkg::OFS_BOARD_COMMAND, sccs_pkg::CMD_STOP);
		// divided external clock: 40 edges at 80 ns through divider 4
		wr(sccs_pkg::OFS_TRIGGER_MODE, sccs_pkg::FREE_RUN_TRIGGER);
		wr(sccs_pkg::OFS_EXT_CLOCK_ENABLE, 32'h0000_0001);
		wr(sccs_pkg::OFS_EXT_CLOCK_DIVIDER, 32'h0000_0004);
		// 12.5 MS/s band: medium for two channels, large for four, small for one
		wr(sccs_pkg::OFS_EXT_CLOCK_BAND, sccs_pkg::BAND_MEDIUM);
		wr(sccs_pkg::OFS_EXT_CLOCK_BAND, sccs_pkg::BAND_LARGE);
		wr(sccs_pkg::OFS_EXT_CLOCK_BAND, sccs_pkg::BAND_SMALL);
		rd(sccs_pkg::OFS_EXT_CLOCK_BAND, sccs_pkg::BAND_SMALL);
		wr(sccs_pkg::OFS_BOARD_COMMAND, sccs_pkg::CMD_START);
		wait_run(k);
		src_en = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		cnt = n_tick;
		repeat (640) @(negedge clk_sys_i);
		ok = (n_tick - cnt >= 9) && (n_tick - cnt <= 11);
		chk({31'h0, ok}, 32'h0000_0001);
		src_en = 1'b0;
		wr(sccs_pkg::OFS_BOARD_COMMAND, sccs_pkg::CMD_STOP);
		finish_test();
	end
endmodule
